// ### core/mla_pkg.sv
// shared constants, types and address decode for the lock and i/o access block
package mla_pkg;

  // ----------------------------------------------------------------
  // lock key
  // ----------------------------------------------------------------
  localparam logic [31:0] KEY_UNLOCK     = 32'h5CC5C55C;
  localparam logic [31:0] KEY_RESET      = 32'h5CC5C55C;
  localparam logic [15:0] KEY_OFFSET     = 16'h0000;
  localparam logic [7:0]  LOCKING_BYTE   = 8'h00;

  // ----------------------------------------------------------------
  // scratch registers
  // ----------------------------------------------------------------
  localparam logic [7:0]  SCRATCH_RESET  = 8'h00;
  localparam logic [15:0] SCRATCH_OFF_0  = 16'h0000;
  localparam logic [15:0] SCRATCH_OFF_3  = 16'h0003;

  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam logic [15:0] IO_SINGLE_LAST = 16'h003F;
  localparam logic [15:0] IO_BIT_LAST    = 16'h001F;
  localparam logic [15:0] IO_EXT_LAST    = 16'h103F;
  localparam logic [15:0] SCRATCH_BASE   = 16'h001C;
  localparam logic [15:0] WIDE16_BASE    = 16'h0F20;
  localparam logic [15:0] WIDE24_BASE    = 16'h0F24;
  localparam logic [15:0] KEY_BASE       = 16'h1040;
  localparam logic [15:0] KEY_LAST       = 16'h1043;
  localparam logic [15:0] FUSE_BASE      = 16'h1050;
  localparam logic [15:0] FUSE_LAST      = 16'h107F;
  localparam logic [15:0] UROW_BASE      = 16'h1080;
  localparam logic [15:0] UROW_LAST      = 16'h10FF;
  localparam logic [15:0] SIG_BASE       = 16'h1100;
  localparam logic [15:0] SIG_LAST       = 16'h11FF;
  localparam logic [15:0] EE_BASE        = 16'h1400;
  localparam logic [15:0] EE_LAST        = 16'h15FF;
  localparam logic [15:0] SRAM_BASE      = 16'h7000;
  localparam logic [15:0] SRAM_LAST      = 16'h7FFF;
  localparam logic [15:0] FLASH_BASE     = 16'h8000;

  typedef enum logic [3:0] {
    R_NONE    = 4'h0,
    R_IO      = 4'h1,
    R_KEY     = 4'h2,
    R_FUSE    = 4'h3,
    R_UROW    = 4'h4,
    R_SIG     = 4'h5,
    R_EEPROM  = 4'h6,
    R_SRAM    = 4'h7,
    R_FLASH   = 4'h8
  } mla_region_t;

  typedef enum logic [2:0] {
    K_LOAD_STORE        = 3'h0,
    K_IN_OUT            = 3'h1,
    K_SET_IO_BIT        = 3'h2,
    K_CLEAR_IO_BIT      = 3'h3,
    K_SKIP_IF_BIT_SET   = 3'h4,
    K_SKIP_IF_BIT_CLEAR = 3'h5
  } mla_kind_t;

  function automatic mla_region_t mla_region_of(input logic [15:0] a);
    if (a <= IO_EXT_LAST) return R_IO;
    else if (a >= KEY_BASE && a <= KEY_LAST) return R_KEY;
    else if (a >= FUSE_BASE && a <= FUSE_LAST) return R_FUSE;
    else if (a >= UROW_BASE && a <= UROW_LAST) return R_UROW;
    else if (a >= SIG_BASE && a <= SIG_LAST) return R_SIG;
    else if (a >= EE_BASE && a <= EE_LAST) return R_EEPROM;
    else if (a >= SRAM_BASE && a <= SRAM_LAST) return R_SRAM;
    else if (a >= FLASH_BASE) return R_FLASH;
    else return R_NONE;
  endfunction

endpackage

// ### core/mla_bus_if.sv
// interface joining the access-control block and its two bus masters
`timescale 1ns/1ns
interface mla_bus_if (
  input wire logic clk,   // system clock
  input wire logic rstn   // synchronous reset, active low
);
  logic                cpu_req;
  logic                cpu_we;
  mla_pkg::mla_kind_t  cpu_kind;
  logic [15:0]         cpu_addr;
  logic [7:0]          cpu_wdata;
  logic [2:0]          cpu_bit;
  logic                cpu_ack;
  logic [7:0]          cpu_rdata;
  logic                cpu_refused;
  logic                cpu_skip;
  logic                dbg_req;
  logic                dbg_we;
  logic                dbg_fuse_cmd;
  logic                dbg_erase;
  logic [15:0]         dbg_addr;
  logic [7:0]          dbg_wdata;
  logic                dbg_ready;
  logic                dbg_ack;
  logic [7:0]          dbg_rdata;
  logic                dbg_refused;
  logic                dbg_locked;

  modport dev (
    input  clk, rstn, cpu_req, cpu_we, cpu_kind, cpu_addr, cpu_wdata, cpu_bit,
    input  dbg_req, dbg_we, dbg_fuse_cmd, dbg_erase, dbg_addr, dbg_wdata,
    output cpu_ack, cpu_rdata, cpu_refused, cpu_skip,
    output dbg_ready, dbg_ack, dbg_rdata, dbg_refused, dbg_locked
  );

  modport mst (
    input  clk, rstn, cpu_ack, cpu_rdata, cpu_refused, cpu_skip,
    input  dbg_ready, dbg_ack, dbg_rdata, dbg_refused, dbg_locked,
    output cpu_req, cpu_we, cpu_kind, cpu_addr, cpu_wdata, cpu_bit,
    output dbg_req, dbg_we, dbg_fuse_cmd, dbg_erase, dbg_addr, dbg_wdata
  );
endinterface

// ### core/mla_device.sv
// lock key, access gating, i/o decode, wide-register staging and scratch registers
`timescale 1ns/1ns
module mla_device (
  mla_bus_if.dev              bus,                      // both masters
  input  wire logic           preserve_eeprom_on_erase, // keep eeprom on erase, only while unlocked
  input  wire logic [7:0]     mem_rdata,                // memory read data, same cycle
  output logic                mem_req,                  // memory access strobe
  output logic                mem_we,                   // memory write
  output logic [15:0]         mem_addr,                 // memory address
  output logic [7:0]          mem_wdata,                // memory write data
  output logic                mem_from_dbg,             // access issued by debug port
  output logic                locked,                   // device locked
  output logic                full_device_erase,        // erase flash and sram pulse
  output logic                erase_eeprom,             // erase eeprom pulse
  output logic [15:0]         wide16_value,             // 16-bit register contents
  output logic [23:0]         wide24_value              // 24-bit register contents
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0]      key;
    logic [3:0][7:0]  scratch;
    logic [15:0]      wide16;
    logic [23:0]      wide24;
    logic [7:0]       temp0;
    logic [7:0]       temp1;
    logic             cpu_ack;
    logic [7:0]       cpu_rdata;
    logic             cpu_refused;
    logic             cpu_skip;
    logic             dbg_ack;
    logic [7:0]       dbg_rdata;
    logic             dbg_refused;
    logic             erase_all;
    logic             erase_ee;
  } mla_dev_state_t;

  mla_dev_state_t s_reg;
  mla_dev_state_t s_next;

  logic                   is_locked;
  logic                   sel_cpu;
  logic                   sel_dbg;
  logic                   do_erase;
  logic [15:0]            a;
  logic                   we;
  logic [7:0]             wd;
  mla_pkg::mla_kind_t     kind;
  mla_pkg::mla_region_t   reg_n;
  logic                   kind_ok;
  logic                   allowed;
  logic                   ok;
  logic                   hit_scratch;
  logic                   hit_w16;
  logic                   hit_w24;
  logic                   internal;
  logic [1:0]             sidx;
  logic [1:0]             widx;
  logic [7:0]             rd;
  logic [7:0]             bitmask;
  logic                   bit_op;
  logic                   bit_val;
  logic [7:0]             wv;
  logic                   do_write;

  assign is_locked = (s_reg.key != mla_pkg::KEY_UNLOCK);

  // ----------------------------------------------------------------
  // request selection, cpu first
  // ----------------------------------------------------------------
  assign sel_cpu  = bus.cpu_req;
  assign sel_dbg  = !bus.cpu_req && bus.dbg_req;
  assign do_erase = sel_dbg && bus.dbg_erase;
  assign a        = sel_cpu ? bus.cpu_addr : bus.dbg_addr;
  assign we       = sel_cpu ? bus.cpu_we : bus.dbg_we;
  assign wd       = sel_cpu ? bus.cpu_wdata : bus.dbg_wdata;
  assign kind     = sel_cpu ? bus.cpu_kind : mla_pkg::K_LOAD_STORE;
  assign reg_n    = mla_pkg::mla_region_of(a);

  // ----------------------------------------------------------------
  // instruction reach and access matrix
  // ----------------------------------------------------------------
  always_comb
  begin
    case (kind)
      mla_pkg::K_LOAD_STORE: kind_ok = 1'b1;
      mla_pkg::K_IN_OUT:     kind_ok = (a <= mla_pkg::IO_SINGLE_LAST);
      mla_pkg::K_SET_IO_BIT, mla_pkg::K_CLEAR_IO_BIT,
      mla_pkg::K_SKIP_IF_BIT_SET, mla_pkg::K_SKIP_IF_BIT_CLEAR:
                             kind_ok = (a <= mla_pkg::IO_BIT_LAST);
      default:               kind_ok = 1'b0;
    endcase
  end

  always_comb
  begin
    allowed = 1'b0;
    if (reg_n == mla_pkg::R_NONE)
      allowed = 1'b0;
    else if (sel_cpu)
    begin
      // cpu rights do not depend on the lock
      allowed = !we || !(reg_n == mla_pkg::R_SIG || reg_n == mla_pkg::R_FUSE ||
                         reg_n == mla_pkg::R_KEY);
    end
    else if (!is_locked)
      allowed = !(we && reg_n == mla_pkg::R_SIG);
    else
      allowed = we && bus.dbg_fuse_cmd && reg_n == mla_pkg::R_UROW;
  end

  assign ok = (sel_cpu || (sel_dbg && !bus.dbg_erase)) && kind_ok && allowed;

  // ----------------------------------------------------------------
  // internal register decode
  // ----------------------------------------------------------------
  assign hit_scratch = (a >= mla_pkg::SCRATCH_BASE + mla_pkg::SCRATCH_OFF_0) &&
                       (a <= mla_pkg::SCRATCH_BASE + mla_pkg::SCRATCH_OFF_3);
  assign hit_w16     = (a >= mla_pkg::WIDE16_BASE) && (a <= mla_pkg::WIDE16_BASE + 16'h0001);
  assign hit_w24     = (a >= mla_pkg::WIDE24_BASE) && (a <= mla_pkg::WIDE24_BASE + 16'h0002);
  assign internal    = hit_scratch || hit_w16 || hit_w24 || reg_n == mla_pkg::R_KEY;
  assign sidx        = 2'(a - mla_pkg::SCRATCH_BASE);
  assign widx        = hit_w16 ? 2'(a - mla_pkg::WIDE16_BASE) : 2'(a - mla_pkg::WIDE24_BASE);

  always_comb
  begin
    if (hit_scratch)
      rd = s_reg.scratch[sidx];
    else if (hit_w16)
      rd = (widx == 2'h0) ? s_reg.wide16[7:0] : s_reg.temp0;
    else if (hit_w24)
    begin
      case (widx)
        2'h0:    rd = s_reg.wide24[7:0];
        2'h1:    rd = s_reg.temp0;
        default: rd = s_reg.temp1;
      endcase
    end
    else if (reg_n == mla_pkg::R_KEY)
      rd = s_reg.key[8 * 2'(a - mla_pkg::KEY_BASE - mla_pkg::KEY_OFFSET) +: 8];
    else
      rd = mem_rdata;
  end

  // ----------------------------------------------------------------
  // bit operations as read-modify-write
  // ----------------------------------------------------------------
  assign bitmask  = 8'h01 << bus.cpu_bit;
  assign bit_op   = (kind == mla_pkg::K_SET_IO_BIT) || (kind == mla_pkg::K_CLEAR_IO_BIT);
  assign bit_val  = |(rd & bitmask);
  assign wv       = (kind == mla_pkg::K_SET_IO_BIT)   ? (rd | bitmask) :
                    (kind == mla_pkg::K_CLEAR_IO_BIT) ? (rd & ~bitmask) : wd;
  assign do_write = ok && (we || bit_op);

  // memory side sees only requests that passed the gate
  assign mem_req      = ok && !internal;
  assign mem_we       = do_write;
  assign mem_addr     = a;
  assign mem_wdata    = wv;
  assign mem_from_dbg = sel_dbg;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next             = s_reg;
    s_next.cpu_ack     = sel_cpu;
    s_next.dbg_ack     = sel_dbg;
    s_next.cpu_refused = sel_cpu && !ok;
    s_next.dbg_refused = sel_dbg && !ok && !do_erase;
    s_next.cpu_rdata   = (sel_cpu && ok && !we) ? rd : 8'h00;
    s_next.dbg_rdata   = (sel_dbg && ok && !we) ? rd : 8'h00;
    s_next.cpu_skip    = sel_cpu && ok &&
                         ((kind == mla_pkg::K_SKIP_IF_BIT_SET && bit_val) ||
                          (kind == mla_pkg::K_SKIP_IF_BIT_CLEAR && !bit_val));
    s_next.erase_all   = do_erase;
    s_next.erase_ee    = do_erase && (is_locked || !preserve_eeprom_on_erase);
    if (do_erase)
    begin
      // reset and erase are the only ways back to unlocked; eeprom survives an unlocked erase with preserve_eeprom_on_erase set
      s_next.key     = mla_pkg::KEY_UNLOCK;
      s_next.scratch = {4{mla_pkg::SCRATCH_RESET}};
      s_next.wide16  = '0;
      s_next.wide24  = '0;
      s_next.temp0   = '0;
      s_next.temp1   = '0;
    end
    else if (do_write && hit_scratch)
      s_next.scratch[sidx] = wv;
    else if (do_write && reg_n == mla_pkg::R_KEY)
      s_next.key[8 * 2'(a - mla_pkg::KEY_BASE - mla_pkg::KEY_OFFSET) +: 8] = wd;
    else if (ok && hit_w16)
    begin
      if (we && widx == 2'h0)
        s_next.temp0 = wd;
      else if (we)
        s_next.wide16 = {wd, s_reg.temp0};
      else if (widx == 2'h0)
        s_next.temp0 = s_reg.wide16[15:8];
    end
    else if (ok && hit_w24)
    begin
      if (we && widx == 2'h0)
        s_next.temp0 = wd;
      else if (we && widx == 2'h1)
        s_next.temp1 = wd;
      else if (we)
        s_next.wide24 = {wd, s_reg.temp1, s_reg.temp0};
      else if (widx == 2'h0)
      begin
        s_next.temp0 = s_reg.wide24[15:8];
        s_next.temp1 = s_reg.wide24[23:16];
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge bus.clk)
  begin
    if (!bus.rstn)
    begin
      s_reg         <= '0;
      s_reg.key     <= mla_pkg::KEY_RESET;
      s_reg.scratch <= {4{mla_pkg::SCRATCH_RESET}};
    end
    else
      s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus.cpu_ack      = s_reg.cpu_ack;
  assign bus.cpu_rdata    = s_reg.cpu_rdata;
  assign bus.cpu_refused  = s_reg.cpu_refused;
  assign bus.cpu_skip     = s_reg.cpu_skip;
  assign bus.dbg_ready    = !bus.cpu_req;
  assign bus.dbg_ack      = s_reg.dbg_ack;
  assign bus.dbg_rdata    = s_reg.dbg_rdata;
  assign bus.dbg_refused  = s_reg.dbg_refused;
  assign bus.dbg_locked   = is_locked;
  assign locked           = is_locked;
  assign full_device_erase = s_reg.erase_all;
  assign erase_eeprom     = s_reg.erase_ee;
  assign wide16_value     = s_reg.wide16;
  assign wide24_value     = s_reg.wide24;

endmodule

// ### core/mla_master.sv
// bus master end: runs byte sequences for the cpu or debug port
`timescale 1ns/1ns
module mla_master (
  mla_bus_if.mst              bus,        // toward the device
  input  wire logic           cmd_valid,  // command offered
  output logic                cmd_ready,  // command taken when high with valid
  input  wire logic           cmd_dbg,    // issue on debug port
  input  wire logic [2:0]     cmd_kind,   // instruction kind, cpu only
  input  wire logic           cmd_we,     // write
  input  wire logic           cmd_fuse,   // debug fuse write command
  input  wire logic           cmd_erase,  // debug full device erase
  input  wire logic           cmd_lock,   // lock the device
  input  wire logic [1:0]     cmd_bytes,  // 1, 2 or 3 bytes
  input  wire logic [15:0]    cmd_addr,   // lowest byte address
  input  wire logic [23:0]    cmd_wdata,  // write data, lsb first
  input  wire logic [2:0]     cmd_bit,    // bit number for bit ops
  output logic                res_valid,  // result, one cycle
  output logic [23:0]         res_data,   // read data
  output logic                res_refused,// any byte refused
  output logic                res_skip    // skip answer
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    M_IDLE  = 2'b00,
    M_ISSUE = 2'b01,
    M_WAIT  = 2'b10,
    M_DONE  = 2'b11
  } mla_mst_st_t;

  typedef struct packed {
    mla_mst_st_t  st;
    logic         dbg;
    logic [2:0]   kind;
    logic         we;
    logic         fuse;
    logic         erase;
    logic [1:0]   last;
    logic [1:0]   idx;
    logic [15:0]  addr;
    logic [23:0]  wdata;
    logic [2:0]   bitn;
    logic [23:0]  data;
    logic         refused;
    logic         skip;
  } mla_mst_state_t;

  mla_mst_state_t m_reg;
  mla_mst_state_t m_next;
  logic           ack;

  assign ack = m_reg.dbg ? bus.dbg_ack : bus.cpu_ack;

  // ----------------------------------------------------------------
  // sequencing, one command at a time, bytes ascending
  // ----------------------------------------------------------------
  always_comb
  begin
    m_next = m_reg;
    case (m_reg.st)
      M_IDLE:
        if (cmd_valid)
        begin
          m_next.dbg     = cmd_dbg || cmd_lock || cmd_erase;
          m_next.kind    = cmd_dbg ? 3'h0 : cmd_kind;
          m_next.we      = cmd_we || cmd_lock;
          m_next.fuse    = cmd_fuse;
          m_next.erase   = cmd_erase;
          m_next.last    = (cmd_lock || cmd_erase || cmd_bytes == 2'h0) ? 2'h0
                           : 2'(cmd_bytes - 2'h1);
          m_next.idx     = 2'h0;
          m_next.addr    = cmd_lock ? mla_pkg::KEY_BASE : cmd_addr;
          m_next.wdata   = cmd_lock ? {16'h0000, mla_pkg::LOCKING_BYTE} : cmd_wdata;
          m_next.bitn    = cmd_bit;
          m_next.data    = '0;
          m_next.refused = 1'b0;
          m_next.skip    = 1'b0;
          m_next.st      = M_ISSUE;
          // reserved addresses are never written
          if ((cmd_we || cmd_lock) && !cmd_erase &&
              mla_pkg::mla_region_of(cmd_lock ? mla_pkg::KEY_BASE : cmd_addr)
              == mla_pkg::R_NONE)
          begin
            m_next.refused = 1'b1;
            m_next.st      = M_DONE;
          end
        end
      M_ISSUE:
        if (!m_reg.dbg || bus.dbg_ready)
          m_next.st = M_WAIT;
      M_WAIT:
        if (ack)
        begin
          m_next.data[8 * m_reg.idx +: 8] = m_reg.dbg ? bus.dbg_rdata : bus.cpu_rdata;
          m_next.refused = m_reg.refused | (m_reg.dbg ? bus.dbg_refused : bus.cpu_refused);
          m_next.skip    = !m_reg.dbg && bus.cpu_skip;
          if (m_reg.idx == m_reg.last)
            m_next.st = M_DONE;
          else
          begin
            m_next.idx = 2'(m_reg.idx + 2'h1);
            m_next.st  = M_ISSUE;
          end
        end
      M_DONE:
        m_next.st = M_IDLE;
      default:
        m_next.st = M_IDLE;
    endcase
  end

  always_ff @(posedge bus.clk)
  begin
    if (!bus.rstn)
      m_reg <= '0;
    else
      m_reg <= m_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cmd_ready        = (m_reg.st == M_IDLE);
  assign bus.cpu_req      = (m_reg.st == M_ISSUE) && !m_reg.dbg;
  assign bus.cpu_we       = m_reg.we;
  assign bus.cpu_kind     = mla_pkg::mla_kind_t'(m_reg.kind);
  assign bus.cpu_addr     = 16'(m_reg.addr + {14'h0000, m_reg.idx});
  assign bus.cpu_wdata    = m_reg.wdata[8 * m_reg.idx +: 8];
  assign bus.cpu_bit      = m_reg.bitn;
  assign bus.dbg_req      = (m_reg.st == M_ISSUE) && m_reg.dbg;
  assign bus.dbg_we       = m_reg.we;
  assign bus.dbg_fuse_cmd = m_reg.fuse;
  assign bus.dbg_erase    = m_reg.erase;
  assign bus.dbg_addr     = 16'(m_reg.addr + {14'h0000, m_reg.idx});
  assign bus.dbg_wdata    = m_reg.wdata[8 * m_reg.idx +: 8];
  assign res_valid        = (m_reg.st == M_DONE);
  assign res_data         = m_reg.data;
  assign res_refused      = m_reg.refused;
  assign res_skip         = m_reg.skip;

endmodule

// ### testbench/mla_properties.sv
// concurrent checks on the bus between the masters and the device
`timescale 1ns/1ns
module mla_properties (
  input wire logic               clk,          // clock
  input wire logic               rstn,         // reset, active low
  input wire logic               cpu_req,      // cpu request
  input wire logic               cpu_we,       // cpu write
  input wire mla_pkg::mla_kind_t cpu_kind,     // cpu kind
  input wire logic [15:0]        cpu_addr,     // cpu address
  input wire logic               cpu_ack,      // cpu answer
  input wire logic               cpu_refused,  // cpu refusal
  input wire logic               dbg_req,      // debug request
  input wire logic               dbg_we,       // debug write
  input wire logic               dbg_fuse_cmd, // fuse write command
  input wire logic               dbg_erase,    // erase request
  input wire logic [15:0]        dbg_addr,     // debug address
  input wire logic               dbg_ready,    // debug may go
  input wire logic               dbg_ack,      // debug answer
  input wire logic [7:0]         dbg_rdata,    // debug read data
  input wire logic               dbg_refused,  // debug refusal
  input wire logic               dbg_locked    // lock state
);
  logic dt;
  logic urw;
  assign dt = dbg_req && dbg_ready;
  assign urw = dbg_we && dbg_fuse_cmd && dbg_addr[15:7] == 9'h021;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_dbg_take_gate: assert property (!dt |=> !dbg_ack)
    else $error("debug answered without being taken");
  a_lock_refuse_dbg: assert property (dt && dbg_locked && !dbg_erase && !urw |=>
    dbg_ack && dbg_refused && dbg_rdata == 8'h00) else $error("locked debug access not blocked");
  a_lock_urow_write: assert property (dt && dbg_locked && urw |=> dbg_ack && !dbg_refused)
    else $error("locked user row write refused");
  a_erase_unlocks: assert property (dt && dbg_erase |=> dbg_ack && !dbg_refused && !dbg_locked)
    else $error("erase did not unlock");
  a_inout_range: assert property (cpu_req && cpu_kind == mla_pkg::K_IN_OUT &&
    cpu_addr > 16'h003F |=> cpu_refused) else $error("in/out beyond single-cycle range");
  a_bit_op_range: assert property (cpu_req && cpu_kind >= mla_pkg::K_SET_IO_BIT &&
    cpu_addr > 16'h001F |=> cpu_refused) else $error("bit op beyond bit range");
  a_cpu_prot_write: assert property (cpu_req && cpu_we && cpu_addr >= 16'h1040 &&
    cpu_addr <= 16'h11FF && cpu_addr[15:7] != 9'h021 |=> cpu_refused) else $error("cpu wrote protected");
  a_cpu_mem_free: assert property (cpu_req && cpu_kind == mla_pkg::K_LOAD_STORE &&
    cpu_addr >= 16'h7000 |=> cpu_ack && !cpu_refused) else $error("cpu memory access blocked");
  a_cpu_ack_next: assert property (cpu_req |=> cpu_ack ##1 !cpu_ack)
    else $error("cpu answer not one cycle after request");
  c_urow_locked: cover property (dt && dbg_locked && urw);
  c_erase_locked: cover property (dt && dbg_erase && dbg_locked);
  c_skip_set: cover property (cpu_req && cpu_kind == mla_pkg::K_SKIP_IF_BIT_SET);
endmodule

// ### testbench/memory_lock_and_io_access_tb.sv
// testbench joining both ends across the bus interface
`timescale 1ns/1ns
module memory_lock_and_io_access_tb;
  logic clk, rstn, cv, pres, rv, rr, rs, locked, fde, ee, er_seen;
  logic [4:0] cf;
  logic [2:0] ck, cb;
  logic [1:0] cn;
  logic [15:0] ca, mem_addr, w16;
  logic [23:0] cd, rd, w24;
  logic [7:0] mem_rdata;
  int miscompares, n_compared, cyc;
  mla_bus_if u_mla_bus_if (.clk(clk), .rstn(rstn));
  mla_device u_mla_device (.bus(u_mla_bus_if), .preserve_eeprom_on_erase(pres),
    .mem_rdata(mem_rdata), .mem_req(), .mem_we(), .mem_addr(mem_addr), .mem_wdata(),
    .mem_from_dbg(), .locked(locked), .full_device_erase(fde), .erase_eeprom(ee),
    .wide16_value(w16), .wide24_value(w24));
  mla_master u_mla_master (.bus(u_mla_bus_if), .cmd_valid(cv), .cmd_ready(), .cmd_dbg(cf[4]),
    .cmd_kind(ck), .cmd_we(cf[3]), .cmd_fuse(cf[2]), .cmd_erase(cf[1]), .cmd_lock(cf[0]),
    .cmd_bytes(cn), .cmd_addr(ca), .cmd_wdata(cd), .cmd_bit(cb), .res_valid(rv),
    .res_data(rd), .res_refused(rr), .res_skip(rs));
  mla_properties u_mla_properties (.clk(clk), .rstn(rstn), .cpu_req(u_mla_bus_if.cpu_req),
    .cpu_we(u_mla_bus_if.cpu_we), .cpu_kind(u_mla_bus_if.cpu_kind),
    .cpu_addr(u_mla_bus_if.cpu_addr), .cpu_ack(u_mla_bus_if.cpu_ack),
    .cpu_refused(u_mla_bus_if.cpu_refused), .dbg_req(u_mla_bus_if.dbg_req),
    .dbg_we(u_mla_bus_if.dbg_we), .dbg_fuse_cmd(u_mla_bus_if.dbg_fuse_cmd),
    .dbg_erase(u_mla_bus_if.dbg_erase), .dbg_addr(u_mla_bus_if.dbg_addr),
    .dbg_ready(u_mla_bus_if.dbg_ready), .dbg_ack(u_mla_bus_if.dbg_ack),
    .dbg_rdata(u_mla_bus_if.dbg_rdata), .dbg_refused(u_mla_bus_if.dbg_refused),
    .dbg_locked(u_mla_bus_if.dbg_locked));
  // memory answers with a pattern tied to the address
  assign mem_rdata = mem_addr[7:0] ^ 8'hA5;
  always @(posedge clk) if (fde === 1'b1) er_seen <= ee;
  task print_verdict;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [25:0] s, input logic [25:0] e);
    n_compared++;
    if (s !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // flags: dbg, we, fuse, erase, lock; e is {skip, refused, data}
  task go(input logic [4:0] f, input logic [2:0] k, input logic [1:0] n, input logic [15:0] a,
          input logic [23:0] d, input logic [2:0] b, input logic [25:0] e);
    logic [25:0] m;
    @(posedge clk) #1;
    {cf, ck, cn, ca, cd, cb} = {f, k, n, a, d, b};
    cv = 1'b1;
    @(posedge clk) #1;
    cv = 1'b0;
    for (int i = 0; i < 40 && rv !== 1'b1; i++) @(posedge clk) #1;
    if (rv !== 1'b1) miscompares++;
    m = (f[3] | f[1] | k >= 3'h2) ? 26'h3000000 : {2'h3, n == 2'h3 ? 24'hFFFFFF :
        n == 2'h2 ? 24'h00FFFF : 24'h0000FF};
    chk("result", {rs, rr, rd} & m, e);
  endtask
  task t_scr;
    go(5'h00, 3'h0, 2'h3, 16'h001C, 24'h0, 3'h0, 26'h0);
    go(5'h08, 3'h0, 2'h3, 16'h001C, 24'h332211, 3'h0, 26'h0);
    go(5'h00, 3'h0, 2'h3, 16'h001C, 24'h0, 3'h0, 26'h0332211);
    go(5'h08, 3'h2, 2'h1, 16'h001F, 24'h0, 3'h3, 26'h0);
    go(5'h00, 3'h4, 2'h1, 16'h001F, 24'h0, 3'h3, 26'h2000000);
    go(5'h08, 3'h3, 2'h1, 16'h001F, 24'h0, 3'h3, 26'h0);
    go(5'h00, 3'h5, 2'h1, 16'h001F, 24'h0, 3'h3, 26'h2000000);
    go(5'h00, 3'h1, 2'h1, 16'h001F, 24'h0, 3'h0, 26'h0);
    $display("t_scr done");
  endtask
  task t_rng;
    go(5'h00, 3'h1, 2'h1, 16'h003F, 24'h0, 3'h0, 26'h000009A);
    go(5'h00, 3'h1, 2'h1, 16'h0040, 24'h0, 3'h0, 26'h1000000);
    go(5'h08, 3'h2, 2'h1, 16'h0020, 24'h0, 3'h0, 26'h1000000);
    go(5'h00, 3'h0, 2'h1, 16'h0040, 24'h0, 3'h0, 26'h00000E5);
    go(5'h08, 3'h0, 2'h1, 16'h1050, 24'h1, 3'h0, 26'h1000000);
    go(5'h18, 3'h0, 2'h1, 16'h1100, 24'h1, 3'h0, 26'h1000000);
    go(5'h08, 3'h0, 2'h1, 16'h2000, 24'h1, 3'h0, 26'h1000000);
    $display("t_rng done");
  endtask
  task t_wide;
    go(5'h08, 3'h0, 2'h2, 16'h0F20, 24'hBEEF, 3'h0, 26'h0);
    go(5'h08, 3'h0, 2'h1, 16'h0F20, 24'h12, 3'h0, 26'h0);
    chk("wide16", {10'h000, w16}, 26'h000BEEF);
    go(5'h08, 3'h0, 2'h1, 16'h0F21, 24'h34, 3'h0, 26'h0);
    chk("wide16", {10'h000, w16}, 26'h0003412);
    go(5'h08, 3'h0, 2'h3, 16'h0F24, 24'hC0FFEE, 3'h0, 26'h0);
    chk("wide24", {2'h0, w24}, 26'h0C0FFEE);
    go(5'h00, 3'h0, 2'h3, 16'h0F24, 24'h0, 3'h0, 26'h0C0FFEE);
    go(5'h00, 3'h0, 2'h2, 16'h0F20, 24'h0, 3'h0, 26'h0003412);
    $display("t_wide done");
  endtask
  task t_lock;
    go(5'h10, 3'h0, 2'h1, 16'h7001, 24'h0, 3'h0, 26'h00000A4);
    go(5'h18, 3'h0, 2'h1, 16'h1040, 24'h0, 3'h0, 26'h0);
    chk("locked", {25'h0, locked}, 26'h1);
    go(5'h18, 3'h0, 2'h1, 16'h1040, 24'h5C, 3'h0, 26'h1000000);
    go(5'h10, 3'h0, 2'h1, 16'h7001, 24'h0, 3'h0, 26'h1000000);
    go(5'h10, 3'h0, 2'h1, 16'h001C, 24'h0, 3'h0, 26'h1000000);
    go(5'h00, 3'h0, 2'h1, 16'h7001, 24'h0, 3'h0, 26'h00000A4);
    go(5'h1C, 3'h0, 2'h1, 16'h1080, 24'h55, 3'h0, 26'h0);
    go(5'h10, 3'h0, 2'h1, 16'h1080, 24'h0, 3'h0, 26'h1000000);
    pres = 1'b1;
    go(5'h12, 3'h0, 2'h1, 16'h0000, 24'h0, 3'h0, 26'h0);
    chk("erase_eeprom", {25'h0, er_seen}, 26'h1);
    chk("locked", {25'h0, locked}, 26'h0);
    go(5'h00, 3'h0, 2'h1, 16'h001C, 24'h0, 3'h0, 26'h0);
    go(5'h12, 3'h0, 2'h1, 16'h0000, 24'h0, 3'h0, 26'h0);
    chk("erase_eeprom", {25'h0, er_seen}, 26'h0);
    $display("t_lock done");
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (++cyc == 5000) begin miscompares++; print_verdict; end
  initial
  begin
    {cv, pres, rstn, cf, ck, cn, ca, cd, cb} = '0;
    repeat (12) @(posedge clk);
    #1 rstn = 1'b1;
    t_scr;
    t_rng;
    t_wide;
    t_lock;
    print_verdict;
  end
endmodule
